// File: pjp_port.v
// Two-pin general purpose port slice with direction, drive, read-back and pin interrupt.
// Operation
// - Each of the two pins has a software-writable direction bit.
// - Data and input reads may take up to two bus cycles to follow a direction change.
// - A drive bit selects full drive when clear and about one third when set.
// - The drive bit has no effect on a pin configured as input.
// - After reset both pins are inputs, undriven, full drive, interrupt disabled.
// - The port raises its own interrupt from flag and enable, gated by the global mask.
// - An enabled pin interrupt wakes the device out of stop mode.
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "pjp_defines.vh"

module pjp_port (
	// Clock and reset.
	input  wire       mclk,
	input  wire       reset,
	// Register port.
	input  wire [7:0] addr,
	input  wire [7:0] wdata,
	input  wire       wr_stb,
	input  wire       rd_stb,
	output reg  [7:0] rdata,
	// Pins.
	input  wire [1:0] pin_in,
	output reg  [1:0] pin_out,
	output reg  [1:0] pin_oe,
	output reg  [1:0] pin_reduced,
	// System.
	input  wire       global_irq_mask,
	input  wire       stop_mode,
	output reg        port_irq,
	output reg        wake_req,
	output reg        irq
);

	// Selects the two pin bits out of a register-wide byte.
	function [1:0] pin_field;
		input [7:0] v;
		begin
			pin_field = v[`PJP_PIN_HI:`PJP_PIN_LO];
		end
	endfunction

	// Places the two pin bits back into a byte.
	function [7:0] pin_byte;
		input [1:0] v;
		begin
			pin_byte = {v, 6'h00};
		end
	endfunction

	reg  [1:0] data_ff;
	reg  [1:0] dir_ff;
	reg  [1:0] drive_ff;
	reg  [1:0] ien_ff;
	reg  [1:0] iflag_ff;
	reg  [1:0] edge_ff;
	reg  [1:0] prev_ff;
	reg  [1:0] dir_d1_ff;
	reg  [1:0] dir_d2_ff;
	reg  [1:0] stat_ff;
	reg  [1:0] mask_ff;
	reg  [1:0] nxt_iflag;
	reg  [1:0] nxt_stat;
	reg  [7:0] nxt_rdata;
	wire [1:0] pin_sync;
	wire [1:0] pin_seen;
	wire [1:0] edge_hit;
	wire       wr_data;
	wire       wr_dir;
	wire       wr_drive;
	wire       wr_ien;
	wire       wr_iflag;
	wire       wr_clr;
	wire       wr_mask;
	wire       wr_edge;
	wire       irq_pend;

	assign wr_data  = wr_stb && (addr == `PJP_OFF_DATA);
	assign wr_dir   = wr_stb && (addr == `PJP_OFF_DIR);
	assign wr_drive = wr_stb && (addr == `PJP_OFF_DRIVE);
	assign wr_ien   = wr_stb && (addr == `PJP_OFF_IRQ_EN);
	assign wr_iflag = wr_stb && (addr == `PJP_OFF_IRQ_FLAG);
	assign wr_clr   = wr_stb && (addr == `PJP_OFF_IRQ_CLR);
	assign wr_mask  = wr_stb && (addr == `PJP_OFF_IRQ_MASK);
	assign wr_edge  = wr_stb && (addr == `PJP_OFF_EDGE_SEL);

	pjp_sync u_sync (
		.mclk     (mclk),
		.reset    (reset),
		.pin_raw  (pin_in),
		.pin_sync (pin_sync)
	);

	// sync read-back
	// Each pin reads its own output latch while the delayed direction says output,
	// otherwise the synchronised pin; the delayed direction lags writes by two cycles.
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_pin
			assign pin_seen[gi] = dir_d2_ff[gi] ? data_ff[gi] : pin_sync[gi];
			assign edge_hit[gi] = edge_ff[gi] ? (pin_sync[gi] & ~prev_ff[gi])
			                                  : (~pin_sync[gi] & prev_ff[gi]);
		end
	endgenerate

	always @(posedge mclk or posedge reset) begin
		if (reset) begin
			data_ff   <= `PJP_RST_REG;
			dir_ff    <= `PJP_RST_REG;
			drive_ff  <= `PJP_RST_REG;
			ien_ff    <= `PJP_RST_REG;
			edge_ff   <= `PJP_RST_REG;
			mask_ff   <= `PJP_RST_REG;
			dir_d1_ff <= `PJP_RST_REG;
			dir_d2_ff <= `PJP_RST_REG;
			prev_ff   <= `PJP_RST_REG;
		end else begin
			if (wr_data) begin
				data_ff <= pin_field(wdata);
			end
			if (wr_dir) begin
				dir_ff <= pin_field(wdata);
			end
			if (wr_drive) begin
				drive_ff <= pin_field(wdata);
			end
			if (wr_ien) begin
				ien_ff <= pin_field(wdata);
			end
			if (wr_edge) begin
				edge_ff <= pin_field(wdata);
			end
			if (wr_mask) begin
				mask_ff <= wdata[1:0];
			end
			dir_d1_ff <= dir_ff;
			dir_d2_ff <= dir_d1_ff;
			prev_ff   <= pin_sync;
		end
	end

	always @* begin
		nxt_iflag = iflag_ff;
		if (wr_iflag) begin
			nxt_iflag = nxt_iflag & ~pin_field(wdata);
		end
		nxt_iflag = nxt_iflag | edge_hit;
	end

	// Sticky status: pin event and stop wake-up; set wins over clear.
	always @* begin
		nxt_stat = stat_ff;
		if (wr_clr) begin
			nxt_stat = nxt_stat & ~wdata[1:0];
		end
		if (|edge_hit) begin
			nxt_stat[`PJP_ST_PIN_EVT] = 1'b1;
		end
		if (stop_mode && |(edge_hit & ien_ff)) begin
			nxt_stat[`PJP_ST_WAKE] = 1'b1;
		end
	end

	assign irq_pend = |(iflag_ff & ien_ff);

	always @* begin
		nxt_rdata = 8'h00;
		case (addr)
			`PJP_OFF_DATA:     nxt_rdata = pin_byte(pin_seen);
			`PJP_OFF_INPUT:    nxt_rdata = pin_byte(dir_d2_ff & data_ff | ~dir_d2_ff & pin_sync);
			`PJP_OFF_DIR:      nxt_rdata = pin_byte(dir_ff);
			`PJP_OFF_DRIVE:    nxt_rdata = pin_byte(drive_ff);
			`PJP_OFF_IRQ_EN:   nxt_rdata = pin_byte(ien_ff);
			`PJP_OFF_IRQ_FLAG: nxt_rdata = pin_byte(iflag_ff);
			`PJP_OFF_IRQ_STAT: nxt_rdata = {6'h00, stat_ff};
			`PJP_OFF_IRQ_MASK: nxt_rdata = {6'h00, mask_ff};
			`PJP_OFF_EDGE_SEL: nxt_rdata = pin_byte(edge_ff);
			default:           nxt_rdata = 8'h00;
		endcase
	end

	always @(posedge mclk or posedge reset) begin
		if (reset) begin
			iflag_ff    <= `PJP_RST_REG;
			stat_ff     <= `PJP_RST_REG;
			rdata       <= 8'h00;
			pin_out     <= 2'h0;
			pin_oe      <= 2'h0;
			pin_reduced <= 2'h0;
			port_irq    <= 1'b0;
			wake_req    <= 1'b0;
			irq         <= 1'b0;
		end else begin
			iflag_ff <= nxt_iflag;
			stat_ff  <= nxt_stat;
			rdata    <= rd_stb ? nxt_rdata : 8'h00;
			pin_out  <= data_ff;
			pin_oe <= dir_ff;
			pin_reduced <= drive_ff & dir_ff;
			port_irq <= irq_pend & ~global_irq_mask;
			wake_req <= stop_mode & irq_pend;
			irq      <= |(nxt_stat & mask_ff);
		end
	end

endmodule // pjp_port

`default_nettype wire

// File: pjp_defines.vh
// Constants for the two-pin port slice: offsets, fields, reset values, timing.
`ifndef PJP_DEFINES_VH
`define PJP_DEFINES_VH

// Register offsets.
`define PJP_OFF_DATA      8'h28
`define PJP_OFF_INPUT     8'h29
`define PJP_OFF_DIR       8'h2a
`define PJP_OFF_DRIVE     8'h2b
`define PJP_OFF_IRQ_EN    8'h2e
`define PJP_OFF_IRQ_FLAG  8'h2f
`define PJP_OFF_IRQ_STAT  8'h30
`define PJP_OFF_IRQ_CLR   8'h31
`define PJP_OFF_IRQ_MASK  8'h32
`define PJP_OFF_EDGE_SEL  8'h33

// Field positions: the two pins sit in bits 7 and 6.
`define PJP_PIN_HI        7
`define PJP_PIN_LO        6

// Reset values.
`define PJP_RST_REG       2'h0

// Status bit positions.
`define PJP_ST_PIN_EVT    0
`define PJP_ST_WAKE       1

// Read-back delay after a direction change, in bus cycles.
`define PJP_SYNC_CYCLES   2

`endif

// File: pjp_sync.v
// Two-stage input synchroniser for the port pins.
`timescale 1ns/1ps
`default_nettype none

module pjp_sync (
	// Clock and reset.
	input  wire       mclk,
	input  wire       reset,
	// Raw and synchronised levels.
	input  wire [1:0] pin_raw,
	output wire [1:0] pin_sync
);

	reg [1:0] stage1_ff;
	reg [1:0] stage2_ff;

	always @(posedge mclk or posedge reset) begin
		if (reset) begin
			stage1_ff <= 2'h0;
			stage2_ff <= 2'h0;
		end else begin
			stage1_ff <= pin_raw;
			stage2_ff <= stage1_ff;
		end
	end

	assign pin_sync = stage2_ff;

endmodule // pjp_sync

`default_nettype wire

// File: pjp_port_assertions.sv
// Checker of the port slice pin, read-back and interrupt outputs.
`timescale 1ns/1ps
`default_nettype none
module pjp_port_chk (
	input wire logic       mclk,
	input wire logic       reset,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic       wr_stb,
	input wire logic       rd_stb,
	input wire logic [7:0] rdata,
	input wire logic [1:0] pin_out,
	input wire logic [1:0] pin_oe,
	input wire logic [1:0] pin_reduced,
	input wire logic       global_irq_mask,
	input wire logic       stop_mode,
	input wire logic       port_irq,
	input wire logic       wake_req
);
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	sequence s_dir_wr; wr_stb && addr == 8'h2a; endsequence
	sequence s_drv_wr; wr_stb && addr == 8'h2b; endsequence
	AST_OE: assert property (s_dir_wr |-> ##2 pin_oe == $past(wdata[7:6], 2))
		else $error("enables miss direction");
	AST_RDDIR: assert property (rd_stb && addr == 8'h2a |=> rdata[7:6] == pin_oe)
		else $error("direction read wrong");
	AST_DRV: assert property (s_drv_wr |-> ##2 pin_reduced == ($past(wdata[7:6], 2) & pin_oe))
		else $error("drive wrong");
	AST_RED: assert property ((pin_reduced & ~pin_oe) == 2'h0)
		else $error("reduced on input");
	AST_RST: assert property ($fell(reset) |-> pin_oe == 2'h0 && !port_irq && !wake_req)
		else $error("reset state wrong");
	AST_MASK: assert property (global_irq_mask |=> !port_irq)
		else $error("mask ignored");
	AST_WAKE: assert property (!stop_mode |=> !wake_req)
		else $error("wake outside stop");
	AST_HOLD: assert property ($changed(pin_out) |-> $past(wr_stb, 2) && $past(addr, 2) == 8'h28)
		else $error("pin level moved");
endmodule // pjp_port_chk
bind pjp_port pjp_port_chk chk_u (.mclk, .reset, .addr, .wdata, .wr_stb, .rd_stb, .rdata,
	.pin_out, .pin_oe, .pin_reduced, .global_irq_mask, .stop_mode, .port_irq, .wake_req);
`default_nettype wire

// File: pjp_board.sv
// Board circuitry on the two port pins.
`timescale 1ns/1ps
`default_nettype none
module pjp_board (
	input  wire logic [1:0] pin_out,
	input  wire logic [1:0] pin_oe,
	input  wire logic [1:0] ext_lvl,
	output wire logic [1:0] pin_in
);
	// A driven pin shows the port level, an undriven one the board level.
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule // pjp_board
`default_nettype wire

// File: tb.sv
// Self-checking bench for the port slice.
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic       mclk, reset, wr_stb, rd_stb, gmask, stop, port_irq, wake_req, irq;
	logic [7:0] addr, wdata, rdata, dir, drv, dat, rv;
	logic [1:0] pin_in, pin_out, pin_oe, pin_red, ext;
	logic [7:0] ra [5] = '{8'h2a, 8'h2b, 8'h2e, 8'h2f, 8'h40};
	int         miscompares = 0, num_checks = 0, cyc = 0;
	pjp_port dut_u (.mclk, .reset, .addr, .wdata, .wr_stb, .rd_stb, .rdata, .pin_in, .pin_out,
		.pin_oe, .pin_reduced(pin_red), .global_irq_mask(gmask), .stop_mode(stop), .port_irq,
		.wake_req, .irq);
	pjp_board brd_u (.pin_out, .pin_oe, .ext_lvl(ext), .pin_in);
	initial begin
		mclk = 0;
		forever #12.5 mclk = ~mclk;
	end
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %0t seen %h want %h", $time, seen, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		wr_stb <= 1;
		addr <= a;
		wdata <= d;
		@(posedge mclk);
		wr_stb <= 0;
	endtask
	task rd(input logic [7:0] a);
		@(posedge mclk);
		rd_stb <= 1;
		addr <= a;
		@(posedge mclk);
		rd_stb <= 0;
		#1 rv = rdata;
	endtask
	task sys(input logic [2:0] exp);
		repeat (5) @(posedge mclk);
		#1 chk({5'h0, port_irq, irq, wake_req}, {5'h0, exp});
	endtask
	task conclude;
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 4000) begin
			miscompares++;
			conclude;
		end
	end
	initial begin
		{reset, wr_stb, rd_stb, gmask, stop} = 5'h10;
		{addr, wdata, ext} = 18'h0;
		rv = $urandom(42);
		repeat (20) @(posedge mclk);
		reset <= 0;
		foreach (ra[i]) begin
			rd(ra[i]);
			chk(rv, 8'h0);
		end
		chk({6'h0, pin_oe}, 8'h0);
		repeat (8) begin
			dat = $urandom;
			dir = $urandom;
			drv = $urandom;
			ext <= 2'($urandom);
			wr(8'h28, dat);
			wr(8'h2a, dir);
			wr(8'h2b, drv);
			rd(8'h2a);
			chk(rv, dir & 8'hc0);
			rd(8'h2b);
			chk(rv, drv & 8'hc0);
			chk({2'h0, pin_out, pin_oe, pin_red}, {2'h0, dat[7:6], dir[7:6], dir[7:6] & drv[7:6]});
			for (int k = 0; k < 2; k++) begin
				rd(8'h28 + 8'(k));
				chk(rv, {dir[7:6] & dat[7:6] | ~dir[7:6] & ext, 6'h0});
			end
		end
		ext <= 2'h3;
		wr(8'h2a, 8'h00);
		wr(8'h2f, 8'hc0);
		wr(8'h31, 8'h03);
		wr(8'h2e, 8'h40);
		wr(8'h32, 8'h03);
		ext <= 2'h0;
		sys(3'h6);
		rd(8'h2f);
		chk(rv, 8'hc0);
		gmask <= 1;
		stop <= 1;
		sys(3'h3);
		wr(8'h2f, 8'h40);
		rd(8'h2f);
		chk(rv, 8'h80);
		{gmask, stop} <= 2'h0;
		wr(8'h32, 8'h00);
		sys(3'h0);
		wr(8'h32, 8'h03);
		wr(8'h31, 8'h03);
		sys(3'h0);
		wr(8'h2f, 8'hc0);
		wr(8'h33, 8'hc0);
		stop <= 1;
		ext <= 2'h3;
		repeat (5) @(posedge mclk);
		rd(8'h2f);
		chk(rv, 8'hc0);
		rd(8'h30);
		chk(rv, 8'h03);
		stop <= 0;
		conclude;
	end
endmodule // tb
`default_nettype wire
